// [rtl/fspc_pkg.sv]
// package of constants for the flash self-programming control block
package fspc_pkg;
    // register placement
    localparam logic [7:0] FSPC_DATA_OFFSET = 8'h57;   // data-space offset
    localparam logic [7:0] FSPC_IO_OFFSET = 8'h37;     // i/o-space offset
    localparam logic [7:0] FSPC_RESET = 8'h00;         // control reset value
    // control bit positions
    localparam int FSPC_BIT_IRQ_EN = 7;
    localparam int FSPC_BIT_BUSY = 6;
    localparam int FSPC_BIT_SIG = 5;
    localparam int FSPC_BIT_REEN = 4;
    localparam int FSPC_BIT_LOCK = 3;
    localparam int FSPC_BIT_PWR = 2;
    localparam int FSPC_BIT_PERS = 1;
    localparam int FSPC_BIT_EN = 0;
    // legal command codes in the low five bits
    localparam logic [4:0] FSPC_CMD_FILL = 5'h01;
    localparam logic [4:0] FSPC_CMD_ERASE = 5'h03;
    localparam logic [4:0] FSPC_CMD_WRITE = 5'h05;
    localparam logic [4:0] FSPC_CMD_LOCK = 5'h09;
    localparam logic [4:0] FSPC_CMD_REEN = 5'h11;
    localparam logic [4:0] FSPC_CMD_SIG = 5'h01;       // signature read adds bit 5 on top
    // windows in cycles
    localparam logic [2:0] FSPC_STORE_WIN = 3'h4;
    localparam logic [2:0] FSPC_LOAD_WIN = 3'h3;
    // flash geometry
    localparam int FSPC_PC_W = 12;
    localparam int FSPC_WORD_W = 5;
    localparam int FSPC_PAGE_W = 7;
    localparam int FSPC_PAGE_WORDS = 32;
    localparam logic [13:0] FSPC_STALLING_REGION_START = 14'h3800;
    localparam logic [13:0] FSPC_BOOT_256 = 14'h3f00;
    localparam logic [13:0] FSPC_BOOT_512 = 14'h3e00;
    localparam logic [13:0] FSPC_BOOT_1K = 14'h3c00;
    localparam logic [13:0] FSPC_BOOT_2K = 14'h3800;
    localparam logic [11:0] FSPC_BOOT_SIZE_256 = 12'h100;
    localparam logic [11:0] FSPC_BOOT_SIZE_512 = 12'h200;
    localparam logic [11:0] FSPC_BOOT_SIZE_1K = 12'h400;
    localparam logic [11:0] FSPC_BOOT_SIZE_2K = 12'h800;
    // programming time
    localparam int FSPC_CLK_HZ = 10_000_000;
    localparam int FSPC_PROG_US = 3300;                 // between 3.2 ms and 3.4 ms
    localparam int FSPC_PROG_CYC = FSPC_PROG_US * (FSPC_CLK_HZ / 1_000_000);
endpackage

// [rtl/fspc_timer.sv]
// programming duration timer for the flash self-programming block
`timescale 1ns/1ps
module fspc_timer #(
    parameter int PROG_CYC = fspc_pkg::FSPC_PROG_CYC
) (
    // clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RESET_N,
    // control
    input wire logic i_start,
    output logic o_busy,
    output logic o_done
);
    // state
    typedef struct packed {
        logic busy;
        logic done;
        logic [15:0] count;
    } fspc_tmr_t;
    fspc_tmr_t st, next_st;

    // next-state logic: load on start, count down, pulse done at zero
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (i_start && !st.busy) begin
            next_st.busy = 1'b1;
            next_st.count = 16'(PROG_CYC - 1);
        end else if (st.busy) begin
            if (st.count == 16'h0000) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end else begin
                next_st.count = st.count - 16'h0001;
            end
        end
    end

    // state register
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_busy = st.busy;
    assign o_done = st.done;
endmodule // fspc_timer

// [rtl/fspc_ctrl.sv]
// flash self-programming control: control register, command windows, buffer
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Overview of operation
// - boot fuses pick boot size and start
// - words below 0x3800 are concurrent-read region
// - twelve bit counter, 32 word pages
// - page from pointer 12:6, word 5:1
// - pointer 15:13 ignored; bit zero byte select
// - ready irq while enabled and command idle
// - region program sets busy flag, blocks region
// - busy cleared by re-enable or buffer fill
// - signature read by load; store ignored
// - re-enable store unblocks region when idle
// - re-enable during fill discards buffer
// - lock store writes lock bits from data
// - lock load returns lock or fuse bits
// - write store programs buffer into page
// - erase store clears the chosen page
// - stall core for stalling-region programming
// - fill store puts data pair in buffer
// - enable bit opens four cycle window
// - other command codes do nothing
// - register resets zero at 0x57/0x37
// - programming lasts 3.2 to 3.4 ms
// - programmed bits read zero, unprogrammed one
// ----------------------------------------------------------------------
module fspc_ctrl #(
    parameter int PROG_CYC = fspc_pkg::FSPC_PROG_CYC
) (
    // clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RESET_N,
    // register access from the core
    input wire logic I_REG_WE,
    input wire logic I_REG_RE,
    input wire logic I_REG_IO_SPACE,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    output logic [7:0] O_REG_RDATA,
    // store / load program-memory instructions
    input wire logic I_STORE,
    input wire logic I_LOAD,
    input wire logic [15:0] I_POINTER,
    input wire logic [15:0] I_DATA_PAIR,
    input wire logic I_GLOBAL_IE,
    output logic O_LOAD_HIT,
    output logic [7:0] O_LOAD_DATA,
    // fuses, lock state and signature
    input wire logic I_BOOT_SIZE_FUSE_HI,
    input wire logic I_BOOT_SIZE_FUSE_LO,
    input wire logic [7:0] I_FUSE_LOW,
    input wire logic [7:0] I_SIG_BYTE,
    // flash array side
    output logic O_ERASE_REQ,
    output logic O_WRITE_REQ,
    output logic [6:0] O_PAGE_SELECT,
    output logic [4:0] O_WORD_SELECT,
    output logic [15:0] O_BUF_RDATA,
    output logic [7:0] O_LOCK_BITS,
    output logic [13:0] O_BOOT_START,
    output logic [11:0] O_BOOT_SIZE,
    // core side status
    output logic O_REGION_BUSY,
    output logic O_CPU_STALL,
    output logic O_READY_IRQ
);
    // ------------------------------------------------------------------
    // types and state
    // ------------------------------------------------------------------
    typedef enum {FSPC_IDLE, FSPC_WIN, FSPC_PROG} fspc_phase_t;
    typedef struct packed {
        logic [7:0] ctrl;           // control/status register
        fspc_phase_t phase;         // command phase
        logic [2:0] win;            // remaining window cycles
        logic [2:0] age;            // cycles since command was set
        logic stall;                // core held during programming
        logic filling;              // buffer fill in progress
        logic [7:0] lock;           // lock bits, 1 = unprogrammed
        logic erase_req;
        logic write_req;
        logic [6:0] page;
        logic [4:0] word;
        logic load_hit;
        logic [7:0] load_data;
    } fspc_state_t;
    fspc_state_t st, next_st;
    logic [15:0] buf_mem [fspc_pkg::FSPC_PAGE_WORDS];   // temporary page buffer
    logic buf_we;
    logic buf_clr;
    logic tmr_start;
    logic tmr_busy;
    logic tmr_done;

    // does the register access hit this register at either offset
    function automatic logic fspc_hit(input logic io, input logic [7:0] a);
        fspc_hit = io ? (a == fspc_pkg::FSPC_IO_OFFSET) :
                        (a == fspc_pkg::FSPC_DATA_OFFSET);
    endfunction

    // is a page inside the stalling region
    function automatic logic fspc_in_stall(input logic [6:0] pg);
        fspc_in_stall = ({pg, 7'h00} >= fspc_pkg::FSPC_STALLING_REGION_START);
    endfunction

    wire logic reg_wr = I_REG_WE && fspc_hit(I_REG_IO_SPACE, I_REG_ADDR);
    wire logic [4:0] cmd = st.ctrl[4:0];
    wire logic [6:0] ptr_page = I_POINTER[12:6];
    wire logic [4:0] ptr_word = I_POINTER[5:1];
    wire logic load_ok = (st.phase == FSPC_WIN) && (st.age < fspc_pkg::FSPC_LOAD_WIN);

    // ------------------------------------------------------------------
    // boot region decode from fuses
    // ------------------------------------------------------------------
    // boot start and size from the two fuse bits
    always_comb begin
        case ({I_BOOT_SIZE_FUSE_HI, I_BOOT_SIZE_FUSE_LO})
            2'b11: begin
                O_BOOT_START = fspc_pkg::FSPC_BOOT_256;
                O_BOOT_SIZE = fspc_pkg::FSPC_BOOT_SIZE_256;
            end
            2'b10: begin
                O_BOOT_START = fspc_pkg::FSPC_BOOT_512;
                O_BOOT_SIZE = fspc_pkg::FSPC_BOOT_SIZE_512;
            end
            2'b01: begin
                O_BOOT_START = fspc_pkg::FSPC_BOOT_1K;
                O_BOOT_SIZE = fspc_pkg::FSPC_BOOT_SIZE_1K;
            end
            default: begin
                O_BOOT_START = fspc_pkg::FSPC_BOOT_2K;
                O_BOOT_SIZE = fspc_pkg::FSPC_BOOT_SIZE_2K;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------------
    // one next-state process for register, windows and requests
    always_comb begin
        next_st = st;
        next_st.erase_req = 1'b0;
        next_st.write_req = 1'b0;
        next_st.load_hit = 1'b0;
        buf_we = 1'b0;
        buf_clr = 1'b0;
        tmr_start = 1'b0;
        if (st.age != 3'h7) begin
            next_st.age = st.age + 3'h1;
        end
        case (st.phase)
            FSPC_IDLE: begin
                if (reg_wr) begin
                    next_st.ctrl[fspc_pkg::FSPC_BIT_IRQ_EN] = I_REG_WDATA[7];
                    next_st.ctrl[4:0] = I_REG_WDATA[4:0];   // busy bit stays hardware-owned
                    next_st.ctrl[fspc_pkg::FSPC_BIT_SIG] = I_REG_WDATA[5];
                    if (I_REG_WDATA[fspc_pkg::FSPC_BIT_EN]) begin
                        next_st.phase = FSPC_WIN;
                        next_st.win = fspc_pkg::FSPC_STORE_WIN;
                        next_st.age = 3'h0;
                    end
                    if (I_REG_WDATA[fspc_pkg::FSPC_BIT_REEN] && st.filling) begin
                        buf_clr = 1'b1;
                        next_st.filling = 1'b0;
                    end
                end
            end
            FSPC_WIN: begin
                if (I_LOAD && load_ok && (cmd == fspc_pkg::FSPC_CMD_LOCK)) begin
                    next_st.load_hit = 1'b1;
                    next_st.load_data = I_POINTER[0] ? I_FUSE_LOW : st.lock;
                    next_st.ctrl[5:0] = 6'h00;
                    next_st.phase = FSPC_IDLE;
                end else if (I_LOAD && load_ok && st.ctrl[fspc_pkg::FSPC_BIT_SIG]
                             && (cmd == fspc_pkg::FSPC_CMD_FILL)) begin
                    next_st.load_hit = 1'b1;
                    next_st.load_data = I_SIG_BYTE;
                    next_st.ctrl[5:0] = 6'h00;
                    next_st.phase = FSPC_IDLE;
                end else if (I_STORE) begin
                    next_st.ctrl[5:0] = 6'h00;
                    next_st.phase = FSPC_IDLE;
                    if (st.ctrl[fspc_pkg::FSPC_BIT_SIG]) begin
                        next_st.ctrl[5:0] = 6'h00;
                    end else begin
                        case (cmd)
                            fspc_pkg::FSPC_CMD_FILL: begin
                                buf_we = 1'b1;
                                next_st.filling = 1'b1;
                                next_st.ctrl[fspc_pkg::FSPC_BIT_BUSY] = 1'b0;
                            end
                            fspc_pkg::FSPC_CMD_REEN: begin
                                next_st.ctrl[fspc_pkg::FSPC_BIT_BUSY] = 1'b0;
                            end
                            fspc_pkg::FSPC_CMD_ERASE, fspc_pkg::FSPC_CMD_WRITE,
                            fspc_pkg::FSPC_CMD_LOCK: begin
                                tmr_start = 1'b1;
                                next_st.phase = FSPC_PROG;
                                next_st.ctrl[5:0] = st.ctrl[5:0];
                                next_st.page = ptr_page;
                                if (cmd == fspc_pkg::FSPC_CMD_LOCK) begin
                                    next_st.lock = st.lock & I_DATA_PAIR[7:0];
                                end else begin
                                    next_st.filling = 1'b0;
                                    if (fspc_in_stall(ptr_page)) begin
                                        next_st.stall = 1'b1;
                                    end else begin
                                        next_st.ctrl[fspc_pkg::FSPC_BIT_BUSY] = 1'b1;
                                    end
                                end
                            end
                            default: begin
                                next_st.ctrl[5:0] = 6'h00;
                            end
                        endcase
                    end
                end else if (st.win == 3'h1) begin
                    next_st.ctrl[5:0] = 6'h00;
                    next_st.ctrl[fspc_pkg::FSPC_BIT_BUSY] = st.ctrl[6];
                    next_st.phase = FSPC_IDLE;
                end else begin
                    next_st.win = st.win - 3'h1;
                end
            end
            FSPC_PROG: begin
                if (tmr_done) begin
                    next_st.erase_req = (cmd == fspc_pkg::FSPC_CMD_ERASE);
                    next_st.write_req = (cmd == fspc_pkg::FSPC_CMD_WRITE);
                    if (cmd == fspc_pkg::FSPC_CMD_WRITE) begin
                        buf_clr = 1'b1;
                    end
                    next_st.ctrl[5:0] = 6'h00;      // busy bit 6 waits for a re-enable or fill store
                    next_st.stall = 1'b0;
                    next_st.phase = FSPC_IDLE;
                end
            end
            default: begin
                next_st.phase = FSPC_IDLE;
            end
        endcase
        if (reg_wr && st.phase != FSPC_IDLE) begin
            next_st.ctrl[fspc_pkg::FSPC_BIT_IRQ_EN] = I_REG_WDATA[7];
        end
        if (buf_we) begin
            next_st.word = ptr_word;
        end
    end

    // state register with asynchronous reset
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st <= '0;
            st.ctrl <= fspc_pkg::FSPC_RESET;
            st.phase <= FSPC_IDLE;
            st.lock <= 8'hff;
        end else begin
            st <= next_st;
        end
    end

    // temporary page buffer; erased words read all ones
    always_ff @(posedge I_SYS_CLK) begin
        for (int i = 0; i < fspc_pkg::FSPC_PAGE_WORDS; i++) begin
            if (buf_clr) begin
                buf_mem[i] <= 16'hffff;
            end else if (buf_we && (ptr_word == 5'(i))) begin
                buf_mem[i] <= I_DATA_PAIR;
            end
        end
    end

    // ------------------------------------------------------------------
    // programming timer
    // ------------------------------------------------------------------
    fspc_timer #(
        .PROG_CYC(PROG_CYC)
    ) u_timer (
        .I_SYS_CLK(I_SYS_CLK),
        .I_RESET_N(I_RESET_N),
        .i_start(tmr_start),
        .o_busy(tmr_busy),
        .o_done(tmr_done)
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign O_REG_RDATA = (I_REG_RE && fspc_hit(I_REG_IO_SPACE, I_REG_ADDR)) ? st.ctrl : 8'h00;
    assign O_LOAD_HIT = st.load_hit;
    assign O_LOAD_DATA = st.load_data;
    assign O_ERASE_REQ = st.erase_req;
    assign O_WRITE_REQ = st.write_req;
    assign O_PAGE_SELECT = st.page;
    assign O_WORD_SELECT = st.word;
    assign O_BUF_RDATA = buf_mem[st.word];
    assign O_LOCK_BITS = st.lock;
    assign O_REGION_BUSY = st.ctrl[fspc_pkg::FSPC_BIT_BUSY];
    assign O_CPU_STALL = st.stall;
    // interrupt requested while the command bit reads zero
    assign O_READY_IRQ = st.ctrl[fspc_pkg::FSPC_BIT_IRQ_EN] && I_GLOBAL_IE
                         && !st.ctrl[fspc_pkg::FSPC_BIT_EN];

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_irq;
        @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
        (st.ctrl[7] && I_GLOBAL_IE && !st.ctrl[0]) |-> O_READY_IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("ready irq missing");

    property p_win;
        @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
        (st.phase == FSPC_WIN && !I_STORE && !I_LOAD)[*4] |=> !st.ctrl[0];
    endproperty
    a_win: assert property (p_win) else $error("window not closed");

    property p_expire;
        @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
        $fell(st.ctrl[0]) |-> st.ctrl[5:1] == 5'h00;
    endproperty
    a_expire: assert property (p_expire) else $error("qualifiers left set");

    property p_stall;
        @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
        O_CPU_STALL |-> st.ctrl[0] && st.phase == FSPC_PROG;
    endproperty
    a_stall: assert property (p_stall) else $error("stall outside programming");

    property p_busy;
        @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
        (st.phase == FSPC_WIN && I_STORE && !st.ctrl[5] && (cmd == fspc_pkg::FSPC_CMD_WRITE)
         && !fspc_in_stall(ptr_page)) |=> O_REGION_BUSY;
    endproperty
    a_busy: assert property (p_busy) else $error("busy flag not set");

    property p_fill;
        @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
        (st.phase == FSPC_WIN && I_STORE && !st.ctrl[5] && cmd == fspc_pkg::FSPC_CMD_FILL)
        |=> !O_REGION_BUSY && O_WORD_SELECT == $past(ptr_word);
    endproperty
    a_fill: assert property (p_fill) else $error("fill wrong");

    property p_bad;
        @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
        (st.phase == FSPC_WIN && I_STORE && cmd != fspc_pkg::FSPC_CMD_ERASE
         && cmd != fspc_pkg::FSPC_CMD_WRITE && cmd != fspc_pkg::FSPC_CMD_LOCK) |=> !tmr_busy;
    endproperty
    a_bad: assert property (p_bad) else $error("illegal code started work");

    property p_done;
        @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
        tmr_done |=> st.phase == FSPC_IDLE && !st.ctrl[0];
    endproperty
    a_done: assert property (p_done) else $error("enable not cleared");

    c_write: cover property (@(posedge I_SYS_CLK) O_WRITE_REQ);
    c_load: cover property (@(posedge I_SYS_CLK) O_LOAD_HIT);
    c_stall: cover property (@(posedge I_SYS_CLK) O_CPU_STALL);
endmodule // fspc_ctrl

// [verification/fspc_core_model.sv]
// processor core model issuing register, store and load requests
`timescale 1ns/1ps
module fspc_core_model (
    // clock and answers from the block
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_hit,
    input wire logic [7:0] i_ldata,
    // register requests
    output logic o_we,
    output logic o_re,
    output logic o_io,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata,
    // program-memory instructions
    output logic o_store,
    output logic o_load,
    output logic [15:0] o_ptr,
    output logic [15:0] o_pair
);
    // -----------------------------------
    // idle levels
    // -----------------------------------
    initial begin
        {o_we, o_re, o_io, o_store, o_load} = 5'h00;
        {o_addr, o_wdata, o_ptr, o_pair} = 48'h0;
    end
    // register write; every task is entered at a falling edge
    task automatic wr(input logic io, input logic [7:0] d);
        {o_we, o_io, o_wdata} = {1'b1, io, d};
        o_addr = io ? 8'h37 : 8'h57;
        @(negedge i_clk);
        {o_we, o_addr, o_wdata} = {1'b0, ~o_addr, ~d}; // no stale bus
    endtask
    // register read, data taken at the sampling edge
    task automatic rd(output logic [7:0] v);
        {o_re, o_io, o_addr} = {2'b10, 8'h57};
        @(posedge i_clk);
        v = i_rdata;
        @(negedge i_clk);
        o_re = 1'b0; // address left standing, a following write sets it
    endtask
    // store instruction; pointer bit zero kept clear
    task automatic spm(input logic [15:0] p, input logic [15:0] d);
        {o_store, o_ptr, o_pair} = {1'b1, p & 16'hfffe, d};
        @(negedge i_clk);
        {o_store, o_pair} = {1'b0, ~d};
    endtask
    // load instruction; answer may land one cycle late
    task automatic lpm(input logic [15:0] p, output logic h, output logic [7:0] v);
        {o_load, o_ptr} = {1'b1, p};
        @(negedge i_clk);
        o_load = 1'b0;
        if (i_hit !== 1'b1) @(negedge i_clk);
        {h, v} = {i_hit, i_ldata};
    endtask
endmodule // fspc_core_model

// [verification/flash_self_program_control_tb.sv]
// testbench for the flash self-programming control block
`timescale 1ns/1ps
module flash_self_program_control_tb;
    localparam int PROG = 20; // short programming time keeps the run brief
    logic clk, rst_n, gie, fhi, flo, we, re, io, st, ld, hit, erq, wrq, busy, stall, irq;
    logic [7:0] addr, wdata, rdata, ldata, lock, v;
    logic [15:0] ptr, pair, bufd;
    logic [6:0] page;
    logic [4:0] word;
    logic [13:0] bstart;
    logic [11:0] bsize;
    int err_total, comparisons;
    // -----------------------------------
    // design and core model
    // -----------------------------------
    fspc_ctrl #(.PROG_CYC(PROG)) uut (.I_SYS_CLK(clk), .I_RESET_N(rst_n),
        .I_REG_WE(we), .I_REG_RE(re), .I_REG_IO_SPACE(io), .I_REG_ADDR(addr),
        .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .I_STORE(st), .I_LOAD(ld),
        .I_POINTER(ptr), .I_DATA_PAIR(pair), .I_GLOBAL_IE(gie), .O_LOAD_HIT(hit),
        .O_LOAD_DATA(ldata), .I_BOOT_SIZE_FUSE_HI(fhi), .I_BOOT_SIZE_FUSE_LO(flo),
        .I_FUSE_LOW(8'h5a), .I_SIG_BYTE(8'ha5), .O_ERASE_REQ(erq), .O_WRITE_REQ(wrq),
        .O_PAGE_SELECT(page), .O_WORD_SELECT(word), .O_BUF_RDATA(bufd),
        .O_LOCK_BITS(lock), .O_BOOT_START(bstart), .O_BOOT_SIZE(bsize),
        .O_REGION_BUSY(busy), .O_CPU_STALL(stall), .O_READY_IRQ(irq));
    fspc_core_model core (.i_clk(clk), .i_rdata(rdata), .i_hit(hit), .i_ldata(ldata),
        .o_we(we), .o_re(re), .o_io(io), .o_addr(addr), .o_wdata(wdata), .o_store(st),
        .o_load(ld), .o_ptr(ptr), .o_pair(pair));
    // -----------------------------------
    // shared checks
    // -----------------------------------
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic finish_test;
        if (err_total == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // bounded wait for an end-of-programming pulse
    task automatic wait_req(input bit wr_kind);
        int n;
        for (n = 0; n < 100; n++) begin
            @(negedge clk);
            if ((wr_kind ? wrq : erq) === 1'b1) break;
        end
        if (n == 100) begin
            err_total++;
            finish_test();
        end
    endtask
    // -----------------------------------
    // scenarios
    // -----------------------------------
    task automatic t_boot; // every fuse pair sizes the boot region
        for (int i = 0; i < 4; i++) begin
            {fhi, flo} = i[1:0];
            @(negedge clk);
            chk("boot_size", {4'h0, 12'h800 >> i}, {4'h0, bsize});
            chk("boot_start", 16'h4000 - (16'h800 >> i), {2'b00, bstart});
        end
    endtask
    task automatic t_erase_write; // concurrent-region erase, re-enable, write, refill
        core.wr(1'b0, 8'h03);
        core.spm(16'h0400, 16'h1234);
        chk("busy_erase", 16'h1, {15'h0, busy});
        chk("page", 16'h10, {9'h0, page});
        core.rd(v);
        chk("ctrl_hold", 16'h43, {8'h0, v});
        wait_req(1'b0);
        core.rd(v);
        chk("ctrl_done", 16'h40, {8'h0, v});
        core.wr(1'b1, 8'h11);
        core.spm(16'h0, 16'h0);
        chk("busy_reen", 16'h0, {15'h0, busy});
        core.wr(1'b0, 8'h05);
        core.spm(16'h0400, 16'h0);
        chk("busy_write", 16'h1, {15'h0, busy});
        wait_req(1'b1);
        core.wr(1'b0, 8'h01);
        core.spm(16'hE04b, 16'hbeef);
        chk("busy_fill", 16'h0, {15'h0, busy});
        chk("word", 16'h5, {11'h0, word});
        chk("buf", 16'hbeef, bufd);
        core.wr(1'b0, 8'h21);
        core.spm(16'h0002, 16'h1111);
        chk("sig_store_word", 16'h5, {11'h0, word});
        chk("sig_store_buf", 16'hbeef, bufd);
        core.wr(1'b0, 8'h11);
        chk("buf_abort", 16'hffff, bufd);
        core.spm(16'h0, 16'h0);
        core.wr(1'b0, 8'h07);
        core.spm(16'h0400, 16'h0);
        chk("busy_bad", 16'h0, {15'h0, busy});
        core.rd(v);
        chk("ctrl_bad", 16'h0, {8'h0, v});
    endtask
    task automatic t_stall_lock; // stalling-region erase, lock write and lock reads
        core.wr(1'b0, 8'h03);
        core.spm(16'h1fc0, 16'h0);
        chk("stall", 16'h1, {15'h0, stall});
        wait_req(1'b0);
        chk("stall_end", 16'h0, {15'h0, stall});
        core.wr(1'b0, 8'h09);
        core.spm(16'h0, 16'h00f0);
        repeat (PROG + 5) @(negedge clk);
        chk("lock", 16'hf0, {8'h0, lock});
        core.wr(1'b0, 8'h09);
        core.lpm(16'h0, hit, v);
        chk("lock_read", 16'h1f0, {7'h0, hit, v});
        core.wr(1'b0, 8'h09);
        core.lpm(16'h1, hit, v);
        chk("fuse_read", 16'h15a, {7'h0, hit, v});
        core.wr(1'b0, 8'h21);
        core.lpm(16'h0, hit, v);
        chk("sig_read", 16'h1a5, {7'h0, hit, v});
    endtask
    task automatic t_expire_irq; // unused window, then ready interrupt
        core.wr(1'b0, 8'h05);
        repeat (6) @(negedge clk);
        core.rd(v);
        chk("ctrl_expire", 16'h0, {8'h0, v});
        gie = 1'b1;
        core.wr(1'b1, 8'h80);
        chk("irq_on", 16'h1, {15'h0, irq});
        gie = 1'b0;
        @(negedge clk);
        chk("irq_off", 16'h0, {15'h0, irq});
    endtask
    // -----------------------------------
    // clock, reset and main sequence
    // -----------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        {rst_n, gie, fhi, flo, err_total, comparisons} = '0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        core.rd(v);
        chk("ctrl_reset", 16'h0, {8'h0, v});
        chk("lock_reset", 16'hff, {8'h0, lock});
        t_boot();
        t_erase_write();
        t_stall_lock();
        t_expire_irq();
        finish_test();
    end
endmodule // flash_self_program_control_tb
